// ---- spd_pkg.sv ----
// Purpose: shared constants for the serial presence store slave
// Assumes: 25 MHz reference clock
// Notes: identity-free; no register map
package spd_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_HZ / 1000);
    localparam int MEM_DEPTH = 256;
    localparam int PAGE_BYTES = 16;
    localparam int FIFO_DEPTH = 2;
    localparam logic [3:0] TYPE_MEM = 4'ha;
    localparam logic [3:0] TYPE_PROT = 4'h6;
    localparam logic [2:0] SEL_SET_REV = 3'h1;
    localparam logic [2:0] SEL_CLR_REV = 3'h3;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEL = 3'b001,
        ST_ADDR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_BUSY = 3'b101
    } spd_state_e;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_MEM = 3'b001,
        OP_SET_REV = 3'b010,
        OP_CLR_REV = 3'b011,
        OP_SET_PERM = 3'b100,
        OP_PROT_RD = 3'b101
    } spd_op_e;
endpackage

// ---- spd_eeprom_i2c_slave.sv ----
// Purpose: two-wire slave front end of a 256x8 module config store
// Assumes: scl/sda and pins asynchronous, oversampled at 25 MHz
// Notes: protection flags and array keep no reset (nonvolatile)
`timescale 1ns/1ps
module spd_eeprom_i2c_slave
    import spd_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] chip_sel_in_i,
    input wire logic high_voltage_detect_i,
    input wire logic vdd_low_i,
    output logic busy_o
);
    function automatic spd_op_e decode_sel(input logic [7:0] b,
        input logic [2:0] ce, input logic hv, input logic perm);
        spd_op_e op = OP_NONE;
        if (b[7:4] == TYPE_MEM && b[3:1] == ce) begin
            op = OP_MEM;
        end else if (b[7:4] == TYPE_PROT && !perm) begin
            if (hv && b[3:1] == SEL_SET_REV && !b[0]) begin
                op = OP_SET_REV;
            end else if (hv && b[3:1] == SEL_CLR_REV && !b[0]) begin
                op = OP_CLR_REV;
            end else if (b[3:1] == ce) begin
                op = b[0] ? OP_PROT_RD : OP_SET_PERM;
            end
        end
        return op;
    endfunction
    logic [1:0] rst_sync, scl_sync, sda_sync, hv_sync, low_sync;
    logic [1:0] ce0_sync, ce1_sync, ce2_sync, fifo_cnt;
    logic rst_n, scl_q, sda_q, rise, fall, start_ev, stop_ev;
    spd_state_e state;
    spd_op_e op, sel_op;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, tx, addr, rd_ptr, wr_addr;
    logic after_ack, wr_pend, fifo_wp, fifo_rp;
    logic [16:0] busy_cnt;
    logic [7:0] mem [MEM_DEPTH], page [PAGE_BYTES], fifo [FIFO_DEPTH];
    logic [15:0] page_mask;
    logic prot_rev = 1'b0, prot_perm = 1'b0;
    logic push_valid, push_ready, pop_valid, pop_ready;
    logic byte_done, ack_end, commit_go, mem_we;
    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            {scl_sync, sda_sync, hv_sync, low_sync} <= 8'hf0;
            {ce0_sync, ce1_sync, ce2_sync} <= 6'h00;
            {scl_q, sda_q} <= 2'h3;
        end else if (en_i) begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            hv_sync <= {hv_sync[0], high_voltage_detect_i};
            low_sync <= {low_sync[0], vdd_low_i};
            ce0_sync <= {ce0_sync[0], chip_sel_in_i[0]};
            ce1_sync <= {ce1_sync[0], chip_sel_in_i[1]};
            ce2_sync <= {ce2_sync[0], chip_sel_in_i[2]};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end
    assign rise = scl_sync[1] & ~scl_q;
    assign fall = ~scl_sync[1] & scl_q;
    assign start_ev = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    assign stop_ev = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
    assign byte_done = fall && bit_cnt == LAST_BIT;
    assign ack_end = fall && bit_cnt == ACK_SLOT;
    assign commit_go = stop_ev && after_ack && wr_pend;
    assign pop_ready = ack_end && state == ST_RDATA;
    assign pop_valid = fifo_cnt != 2'h0;
    assign push_valid = state == ST_RDATA;
    assign push_ready = fifo_cnt != 2'(FIFO_DEPTH);
    assign sda_o = 1'b0;
    assign busy_o = state == ST_BUSY;
    assign sel_op = decode_sel(shreg,
        {ce2_sync[1], ce1_sync[1], ce0_sync[1]}, hv_sync[1], prot_perm);
    // protocol engine
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            op <= OP_NONE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= IDLE_BYTE;
            addr <= 8'h00;
            {after_ack, wr_pend, sda_oe_o} <= 3'h0;
            busy_cnt <= 17'h0;
        end else if (en_i) begin
            if (low_sync[1]) begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
                wr_pend <= 1'b0;
            end else if (state == ST_BUSY) begin
                sda_oe_o <= 1'b0;
                if (busy_cnt == 17'(WRITE_CYCLES - 1)) begin
                    state <= ST_IDLE;
                end
                busy_cnt <= busy_cnt + 17'h1;
            end else if (start_ev) begin
                state <= ST_SEL;
                // scl fall closing the start wraps this to zero
                bit_cnt <= 4'hf;
                sda_oe_o <= 1'b0;
                after_ack <= 1'b0;
                wr_pend <= 1'b0;
            end else if (stop_ev) begin
                state <= commit_go ? ST_BUSY : ST_IDLE;
                busy_cnt <= 17'h0;
                sda_oe_o <= 1'b0;
                wr_pend <= 1'b0;
            end else if (state != ST_IDLE) begin
                if (rise) begin
                    if (bit_cnt != ACK_SLOT) begin
                        shreg <= {shreg[6:0], sda_sync[1]};
                    end else if (state == ST_RDATA && sda_sync[1]) begin
                        state <= ST_IDLE;
                    end
                end else if (byte_done) begin
                    bit_cnt <= ACK_SLOT;
                    case (state)
                        ST_SEL: begin
                            op <= sel_op;
                            if (sel_op == OP_NONE) begin
                                state <= ST_IDLE;
                            end else begin
                                sda_oe_o <= 1'b1;
                                state <= shreg[0] ? ST_RDATA : ST_ADDR;
                            end
                        end
                        ST_ADDR: begin
                            addr <= shreg;
                            sda_oe_o <= 1'b1;
                            state <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            addr <= {addr[7:4], addr[3:0] + 4'h1};
                            wr_pend <= 1'b1;
                            sda_oe_o <= 1'b1;
                        end
                        ST_RDATA: sda_oe_o <= 1'b0;
                        default: state <= ST_IDLE;
                    endcase
                end else if (ack_end) begin
                    bit_cnt <= 4'h0;
                    after_ack <= 1'b1;
                    sda_oe_o <= 1'b0;
                    if (state == ST_RDATA && op == OP_PROT_RD) begin
                        state <= ST_IDLE;
                    end else if (state == ST_RDATA) begin
                        tx <= pop_valid ? fifo[fifo_rp] : IDLE_BYTE;
                        sda_oe_o <= pop_valid ? ~fifo[fifo_rp][7] : 1'b0;
                        addr <= addr + 8'h1;
                    end
                end else if (fall) begin
                    // tenth slot ends: a later stop is misplaced
                    after_ack <= 1'b0;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (state == ST_RDATA) begin
                        tx <= {tx[6:0], 1'b1};
                        sda_oe_o <= ~tx[6];
                    end
                end
            end
        end
    end
    // read prefetch buffer, drained by the shifter at ack end
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            {fifo_wp, fifo_rp} <= 2'h0;
            fifo_cnt <= 2'h0;
            rd_ptr <= 8'h00;
        end else if (en_i) begin
            if (start_ev || state != ST_RDATA) begin
                {fifo_wp, fifo_rp} <= 2'h0;
                fifo_cnt <= 2'h0;
                rd_ptr <= addr;
            end else begin
                if (push_valid && push_ready) begin
                    fifo[fifo_wp] <= mem[rd_ptr];
                    fifo_wp <= ~fifo_wp;
                    rd_ptr <= rd_ptr + 8'h1;
                end
                if (pop_valid && pop_ready) begin
                    fifo_rp <= ~fifo_rp;
                end
                fifo_cnt <= fifo_cnt + 2'(push_valid && push_ready)
                    - 2'(pop_valid && pop_ready);
            end
        end
    end
    // page latch and commit into the array during the write cycle
    assign wr_addr = {addr[7:4], busy_cnt[3:0]};
    assign mem_we = state == ST_BUSY && op == OP_MEM
        && busy_cnt < 17'(PAGE_BYTES) && page_mask[busy_cnt[3:0]]
        && !((prot_rev || prot_perm) && !wr_addr[7]);
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            page_mask <= 16'h0;
        end else if (en_i) begin
            if (start_ev && state != ST_BUSY) begin
                page_mask <= 16'h0;
            end else if (byte_done && state == ST_WDATA) begin
                page[addr[3:0]] <= shreg;
                page_mask[addr[3:0]] <= 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (en_i && mem_we) begin
            mem[wr_addr] <= page[busy_cnt[3:0]];
        end
    end
    // protection flags keep their value across reset
    always_ff @(posedge ref_clk_i) begin
        if (en_i && rst_n && !low_sync[1] && state != ST_BUSY
            && commit_go) begin
            case (op)
                OP_SET_REV: prot_rev <= 1'b1;
                OP_CLR_REV: prot_rev <= 1'b0;
                OP_SET_PERM: prot_perm <= 1'b1;
                default: prot_perm <= prot_perm;
            endcase
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);
    chk_addr_ack: assert property (
        (en_i && !low_sync[1] && !start_ev && !stop_ev && byte_done
            && state == ST_ADDR) |=> sda_oe_o)
        else $error("address byte not acknowledged");
    chk_busy_quiet: assert property (
        (state == ST_BUSY) |=> (state == ST_BUSY) |-> !sda_oe_o)
        else $error("slave drove sda during write cycle");
    chk_stop_commit: assert property (
        (en_i && !low_sync[1] && state != ST_BUSY && stop_ev && after_ack
            && wr_pend) |=> state == ST_BUSY ##1 !sda_oe_o)
        else $error("stop after ack did not start write cycle");
    chk_stop_plain: assert property (
        (en_i && !low_sync[1] && state != ST_BUSY && stop_ev
            && !after_ack) |=> state == ST_IDLE)
        else $error("misplaced stop started write cycle");
    chk_perm_mute: assert property (
        (en_i && prot_perm && byte_done && state == ST_SEL
            && shreg[7:4] == TYPE_PROT) |=> !sda_oe_o)
        else $error("protection select acked after permanent lock");
    chk_low_half: assert property (
        mem_we |-> (wr_addr[7] || (!prot_rev && !prot_perm)))
        else $error("protected lower half written");
    chk_supply_low: assert property (
        (en_i && low_sync[1]) |=> state == ST_IDLE && !sda_oe_o)
        else $error("slave active below supply threshold");
    chk_page_wrap: assert property (
        (en_i && !low_sync[1] && !start_ev && !stop_ev && byte_done
            && state == ST_WDATA) |=> addr[7:4] == $past(addr[7:4])
            && addr[3:0] == $past(addr[3:0]) + 4'h1)
        else $error("page address stepped outside page");
    chk_no_match: assert property (
        (en_i && !low_sync[1] && !start_ev && !stop_ev && byte_done
            && state == ST_SEL && shreg[7:4] != TYPE_MEM
            && shreg[7:4] != TYPE_PROT) |=> state == ST_IDLE && !sda_oe_o)
        else $error("foreign select byte answered");
endmodule

// ---- spd_bus_master.sv ----
// Purpose: behavioural two-wire bus master driving the slave's pins
// Assumes: caller sequences start, bytes and stop; inputs change at negedge
// Notes: scl idles high between frames; sda released means pulled high
`timescale 1ns/1ps
module spd_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    localparam int HALF = 8;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // start or repeated start from either scl level
    task automatic start();
        sda_o = 1'b1;
        wait_clk(HALF);
        scl_o = 1'b1;
        wait_clk(HALF);
        sda_o = 1'b0;
        wait_clk(HALF);
        scl_o = 1'b0;
        wait_clk(2);
    endtask

    // data moves only while scl low, sampled at end of high phase
    task automatic clock_bit(input logic b, output logic s);
        sda_o = b;
        wait_clk(HALF);
        scl_o = 1'b1;
        wait_clk(HALF);
        s = sda_i;
        scl_o = 1'b0;
        wait_clk(2);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    // acknowledge every byte but the last one
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(last, s);
    endtask

    task automatic stop();
        sda_o = 1'b0;
        wait_clk(HALF);
        scl_o = 1'b1;
        wait_clk(HALF);
        sda_o = 1'b1;
        wait_clk(HALF);
    endtask
endmodule

// ---- spd_eeprom_i2c_slave_tb.sv ----
// Purpose: self-checking bench for the serial presence store slave
// Assumes: short write cycle parameter; master model drives the wire
// Notes: scenarios run in order; permanent lock is set last
`timescale 1ns/1ps
module spd_eeprom_i2c_slave_tb;
    import spd_pkg::*;
    localparam int WCYC = 64;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic scl, mst_sda, sda_out, sda_oe, busy, hv = 1'b0, vdd_low = 1'b0;
    logic [2:0] csel = 3'h0;
    logic en = 1'b1;
    int err_count = 0;
    int checks = 0;
    wire sda = mst_sda & (sda_oe ? sda_out : 1'b1);

    initial forever #20 clk = ~clk;

    spd_bus_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(mst_sda));

    spd_eeprom_i2c_slave #(.WRITE_CYCLES(WCYC)) uut (
        .ref_clk_i(clk), .arst_n_i(arst_n), .en_i(en), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
        .chip_sel_in_i(csel), .high_voltage_detect_i(hv),
        .vdd_low_i(vdd_low), .busy_o(busy));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check_bit(string name, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            err_count++;
            $display("ERROR busy_wait expected 0 seen %b", busy);
            summarize();
        end
        repeat (4) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] sel, input logic [7:0] addr,
                      input logic [7:0] d[$], input logic exp);
        logic a;
        m.start();
        m.send_byte(sel, a);
        check_bit("sel_ack", exp, a);
        m.send_byte(addr, a);
        check_bit("addr_ack", exp, a);
        foreach (d[i]) begin
            m.send_byte(d[i], a);
            check_bit("data_ack", exp, a);
        end
        m.stop();
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] e[$]);
        logic a;
        logic [7:0] v;
        m.start();
        m.send_byte({TYPE_MEM, 3'h0, 1'b0}, a);
        m.send_byte(addr, a);
        m.start();
        m.send_byte({TYPE_MEM, 3'h0, 1'b1}, a);
        check_bit("rd_sel_ack", 1'b1, a);
        foreach (e[i]) begin
            m.read_byte(i == e.size() - 1, v);
            check_byte("rd_data", e[i], v);
        end
        m.stop();
        wait_idle();
    endtask

    task automatic t_page_write();
        logic a;
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h9e, '{8'h11, 8'h22, 8'h33}, 1'b1);
        check_bit("busy_after_stop", 1'b1, busy);
        m.start();
        m.send_byte({TYPE_MEM, 3'h0, 1'b0}, a);
        check_bit("poll_ack", 1'b0, a);
        m.stop();
        wait_idle();
        rd(8'h9e, '{8'h11, 8'h22});
        rd(8'h90, '{8'h33});
        $display("test page_write done");
    endtask

    // clock enable low must hold the write cycle where it is
    task automatic t_freeze();
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'hc0, '{8'h44}, 1'b1);
        en = 1'b0;
        repeat (100) @(negedge clk);
        check_bit("busy_frozen", 1'b1, busy);
        en = 1'b1;
        wait_idle();
        rd(8'hc0, '{8'h44});
        $display("test freeze done");
    endtask

    task automatic t_select();
        logic a;
        logic [7:0] v;
        csel = 3'h5;
        m.start();
        m.send_byte({TYPE_MEM, 3'h0, 1'b1}, a);
        check_bit("sel_mismatch", 1'b0, a);
        m.start();
        m.send_byte({4'h5, 3'h5, 1'b1}, a);
        check_bit("sel_bad_type", 1'b0, a);
        m.start();
        m.send_byte({TYPE_MEM, 3'h5, 1'b1}, a);
        check_bit("sel_match", 1'b1, a);
        m.read_byte(1'b1, v);
        m.stop();
        csel = 3'h0;
        wait_idle();
        $display("test select done");
    endtask

    task automatic t_protect();
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h10, '{8'h5a}, 1'b1);
        wait_idle();
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h80, '{8'h77}, 1'b1);
        wait_idle();
        hv = 1'b1;
        wr({TYPE_PROT, SEL_SET_REV, 1'b0}, 8'h00, '{8'h00}, 1'b1);
        wait_idle();
        hv = 1'b0;
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h10, '{8'ha5}, 1'b1);
        wait_idle();
        rd(8'h10, '{8'h5a});
        rd(8'h80, '{8'h77});
        wr({TYPE_PROT, SEL_CLR_REV, 1'b0}, 8'h00, '{8'h00}, 1'b0);
        wait_idle();
        hv = 1'b1;
        wr({TYPE_PROT, SEL_CLR_REV, 1'b0}, 8'h00, '{8'h00}, 1'b1);
        wait_idle();
        hv = 1'b0;
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h10, '{8'ha5}, 1'b1);
        wait_idle();
        rd(8'h10, '{8'ha5});
        $display("test protect done");
    endtask

    task automatic t_low_supply();
        vdd_low = 1'b1;
        repeat (4) @(negedge clk);
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h80, '{8'h01}, 1'b0);
        vdd_low = 1'b0;
        wait_idle();
        rd(8'h80, '{8'h77});
        $display("test low_supply done");
    endtask

    task automatic t_permanent();
        logic a;
        logic [7:0] v;
        m.start();
        m.send_byte({TYPE_PROT, 3'h0, 1'b1}, a);
        check_bit("status_ack", 1'b1, a);
        m.read_byte(1'b1, v);
        m.stop();
        wait_idle();
        wr({TYPE_PROT, 3'h0, 1'b0}, 8'h00, '{8'h00}, 1'b1);
        wait_idle();
        m.start();
        m.send_byte({TYPE_PROT, 3'h0, 1'b1}, a);
        check_bit("locked_status", 1'b0, a);
        m.stop();
        wait_idle();
        wr({TYPE_MEM, 3'h0, 1'b0}, 8'h10, '{8'h33}, 1'b1);
        wait_idle();
        rd(8'h10, '{8'ha5});
        $display("test permanent done");
    endtask

    initial begin
        repeat (10) @(negedge clk);
        check_bit("oe_in_reset", 1'b0, sda_oe);
        check_bit("busy_in_reset", 1'b0, busy);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        $display("test reset done");
        t_page_write();
        t_freeze();
        t_select();
        t_protect();
        t_low_supply();
        t_permanent();
        summarize();
    end
endmodule
